// *** mcs_pkg.sv ***
// Purpose: Shared constants for the module control and status block
// Assumes: 200 MHz ref_clk, 8-bit register port driven by the serial bus engine
// Notes:   Addresses are byte addresses on the internal register port
package mcs_pkg;

    // Clock rate and time figures
    localparam int unsigned CLK_MHZ         = 200;
    localparam int unsigned T_SETTLE_US     = 1000;
    localparam int unsigned T_PDOWN_OFF_MS  = 300;
    localparam int unsigned SETTLE_CYCLES   = T_SETTLE_US * CLK_MHZ;
    localparam int unsigned SETTLE_LIMIT    = T_PDOWN_OFF_MS * 1000 * CLK_MHZ;

    // Register addresses
    localparam logic [7:0] ADDR_STATUS  = 8'h02;
    localparam logic [7:0] ADDR_FLAGS   = 8'h03;
    localparam logic [7:0] ADDR_CONTROL = 8'h5d;
    localparam logic [7:0] ADDR_MASK    = 8'h64;
    localparam logic [7:0] ADDR_PINS    = 8'h70;

    // Field positions
    localparam int unsigned BIT_NOT_READY  = 0;
    localparam int unsigned BIT_READY_FLAG = 0;
    localparam int unsigned BIT_PDOWN      = 0;
    localparam int unsigned BIT_PIN_SEL    = 0;
    localparam int unsigned BIT_PIN_TXDIS  = 1;
    localparam int unsigned BIT_PIN_LOWPWR = 2;

    // Reset values
    localparam logic [7:0] RST_MASK    = 8'h00;
    localparam logic [7:0] RST_FLAGS   = 8'h00;
    localparam logic       RST_PDOWN   = 1'b0;
    localparam logic       RST_NREADY  = 1'b1;
    localparam logic [3:0] RST_PINS    = 4'b1011;

    // Commit sequencer states, Gray along idle, transaction, armed
    typedef enum logic [1:0] {
        MCS_IDLE  = 2'b00,
        MCS_TXN   = 2'b01,
        MCS_ARMED = 2'b11
    } mcs_state_t;

endpackage : mcs_pkg

// *** mcs_tmr_if.sv ***
// Purpose: Start and completion signals between control logic and settle timer
// Assumes: Single ref_clk domain
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface mcs_tmr_if;
    logic start;
    logic busy;
    logic done;

    modport ctrl  (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface : mcs_tmr_if
`default_nettype wire

// *** mcs_settle_timer.sv ***
// Purpose: Countdown from power-down release until the module is ready
// Assumes: start restarts the count at any time
// Notes:   done pulses in the last counted cycle
`timescale 1ns/1ps
`default_nettype none
module mcs_settle_timer #(
    parameter int unsigned CYCLES = mcs_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Control side
    mcs_tmr_if.timer  tmr
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] cnt_reg;

    // Restartable down counter
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            cnt_reg <= '0;
        else if (tmr.start)
            cnt_reg <= LOAD;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - ONE;
    end

    assign tmr.busy = (cnt_reg != '0);
    assign tmr.done = (cnt_reg == ONE) && !tmr.start; // A restart swallows completion

endmodule : mcs_settle_timer
`default_nettype wire

// *** mcs_ctrl_status.sv ***
// Purpose: Low-speed control and status response logic of a pluggable module
// Assumes: Register port strobes come from the serial bus engine on ref_clk
// Notes:   Mask and power-down writes commit on the first SCL fall after stop
//
// Behaviour
// [RL1] Clearing a mask bit lets its flag drive the interrupt again within 100 ms.
// [RL2] Select asserted makes the module answer serial traffic within 100 us.
// [RL3] Select deasserted stops the module answering serial traffic within 100 us.
// [RL4] Setting power-down override enters low power within 100 ms.
// [RL5] Clearing power-down override returns to fully functional within 300 ms.
// [RL6] Fully functional: data-not-ready clears, then interrupt asserts.
// [RL7] Write-triggered deadlines start at SCL fall after write stop.
// [RL8] Clear-on-read deadlines start at SCL fall after read stop.
// [RL9] Laser off while disable input high or open, on only while low.
// [RL10] Flag cleared by read releases interrupt high within 500 us.
// [RL11] Setting a mask bit inhibits that flag's interrupt within 100 ms.
// [RL12] Select and interrupt active low; traffic ignored while select high.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mcs_ctrl_status #(
    parameter int unsigned SETTLE_CYCLES = mcs_pkg::SETTLE_CYCLES,
    parameter int unsigned NFLAGS        = 7
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // Register port from serial bus engine
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // Serial bus framing
    input  wire logic              scl_in,
    input  wire logic              bus_stop,
    output logic                   serial_respond_en,
    // Module pins
    input  wire logic              module_select_n,
    input  wire logic              tx_laser_disable_in,
    input  wire logic              low_power_pin,
    output logic                   interrupt_out_n,
    output logic                   laser_enable,
    output logic                   low_power_out,
    // Condition events from the rest of the module
    input  wire logic [NFLAGS-1:0] flag_event_in
);
    localparam int unsigned NW = NFLAGS + 1;

    // Pin synchronisers: 0 select_n, 1 tx disable, 2 low power pin, 3 scl
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_s3_reg;
    logic [3:0] pin_reg;
    logic [3:0] pin_next;
    logic       scl_prev_reg;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pin_s1_reg   <= mcs_pkg::RST_PINS;
            pin_s2_reg   <= mcs_pkg::RST_PINS;
            pin_s3_reg   <= mcs_pkg::RST_PINS;
            pin_reg      <= mcs_pkg::RST_PINS;
            scl_prev_reg <= 1'b1;
        end
        else
        begin
            pin_s1_reg   <= {scl_in, low_power_pin, tx_laser_disable_in, module_select_n};
            pin_s2_reg   <= pin_s1_reg;
            pin_s3_reg   <= pin_s2_reg;
            pin_reg      <= pin_next;
            scl_prev_reg <= pin_reg[3];
        end
    end

    // A pin change counts only once stages two and three agree
    assign pin_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                    | (pin_reg & (pin_s2_reg ^ pin_s3_reg));

    // Selection and bus gating
    wire sel      = !pin_reg[0];              // RL12
    wire scl_fall = scl_prev_reg && !pin_reg[3];
    wire acc_wr   = reg_wr && sel;             // RL12
    wire acc_rd   = reg_rd && sel;             // RL12

    assign serial_respond_en = sel;            // RL2 RL3

    // Address decode
    wire hit_status  = (reg_addr == mcs_pkg::ADDR_STATUS);
    wire hit_flags   = (reg_addr == mcs_pkg::ADDR_FLAGS);
    wire hit_control = (reg_addr == mcs_pkg::ADDR_CONTROL);
    wire hit_mask    = (reg_addr == mcs_pkg::ADDR_MASK);
    wire hit_pins    = (reg_addr == mcs_pkg::ADDR_PINS);

    // Control state
    mcs_pkg::mcs_state_t st_reg;
    mcs_pkg::mcs_state_t st_next;
    logic [NW-1:0] flag_reg;
    logic [NW-1:0] mask_reg;
    logic [NW-1:0] mask_pend_reg;
    logic [NW-1:0] cor_pend_reg;
    logic          pd_reg;
    logic          pd_pend_reg;
    logic          nready_reg;
    logic          lp_prev_reg;
    logic          init_reg;
    logic          irq_n_reg;
    logic          laser_reg;

    wire staged = (acc_wr && (hit_control || hit_mask)) || (acc_rd && hit_flags);
    wire commit = (st_reg == mcs_pkg::MCS_ARMED) && scl_fall; // RL7 RL8

    // Commit sequencer: access, stop, then the next SCL falling edge
    always_comb
    begin
        st_next = st_reg;
        unique case (st_reg)
            mcs_pkg::MCS_IDLE:
                if (staged)
                    st_next = mcs_pkg::MCS_TXN;
            mcs_pkg::MCS_TXN:
                if (bus_stop)
                    st_next = mcs_pkg::MCS_ARMED;
            mcs_pkg::MCS_ARMED:
                if (staged)
                    st_next = mcs_pkg::MCS_TXN;
                else if (scl_fall)
                    st_next = mcs_pkg::MCS_IDLE;
            default:
                st_next = mcs_pkg::MCS_IDLE;
        endcase
    end

    // Power and readiness
    mcs_tmr_if tmr ();
    wire lp_eff = pd_reg || pin_reg[2];
    assign tmr.start = init_reg || (lp_prev_reg && !lp_eff); // RL5
    wire ready_ev = tmr.done && !lp_eff;                      // RL5 RL6
    wire nready_next = lp_eff || tmr.start || (nready_reg && !ready_ev);

    mcs_settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tmr     (tmr)
    );

    // Flags: events set, write-one and committed clear-on-read clear; set wins
    wire [NW-1:0] ev_vec   = {flag_event_in, ready_ev};       // RL6
    wire [NW-1:0] w1c_vec  = (acc_wr && hit_flags) ? reg_wdata[NW-1:0] : '0;
    wire [NW-1:0] cor_vec  = commit ? cor_pend_reg : '0;      // RL8 RL10
    wire [NW-1:0] flag_next = ev_vec | (flag_reg & ~(w1c_vec | cor_vec));
    wire [NW-1:0] cor_next  = (commit ? '0 : cor_pend_reg)
                            | ((acc_rd && hit_flags) ? flag_reg : '0);
    wire [NW-1:0] mask_pnext = (acc_wr && hit_mask) ? reg_wdata[NW-1:0] : mask_pend_reg;
    wire          pd_pnext   = (acc_wr && hit_control) ? reg_wdata[mcs_pkg::BIT_PDOWN]
                                                       : pd_pend_reg;

    // Interrupt level follows unmasked flags
    wire irq_n_next = ~|(flag_reg & ~mask_reg);              // RL1 RL11 RL12

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_reg        <= mcs_pkg::MCS_IDLE;
            flag_reg      <= '0;
            mask_reg      <= '0;
            mask_pend_reg <= '0;
            cor_pend_reg  <= '0;
            pd_reg        <= mcs_pkg::RST_PDOWN;
            pd_pend_reg   <= mcs_pkg::RST_PDOWN;
            nready_reg    <= mcs_pkg::RST_NREADY;
            lp_prev_reg   <= 1'b0;
            init_reg      <= 1'b1;
            irq_n_reg     <= 1'b1;
            laser_reg     <= 1'b0;
        end
        else
        begin
            st_reg        <= st_next;
            flag_reg      <= flag_next;
            cor_pend_reg  <= cor_next;
            mask_pend_reg <= mask_pnext;
            pd_pend_reg   <= pd_pnext;
            if (commit)
            begin
                mask_reg <= mask_pend_reg;                    // RL1 RL11
                pd_reg   <= pd_pend_reg;                      // RL4 RL5
            end
            nready_reg    <= nready_next;
            lp_prev_reg   <= lp_eff;
            init_reg      <= 1'b0;
            irq_n_reg     <= irq_n_next;
            laser_reg     <= !pin_reg[1];                     // RL9
        end
    end

    assign interrupt_out_n = irq_n_reg;
    assign laser_enable    = laser_reg;

    // Low power output registered so it never glitches on the pin
    logic lowpwr_reg;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            lowpwr_reg <= 1'b0;
        else
            lowpwr_reg <= lp_eff;                             // RL4
    end
    assign low_power_out = lowpwr_reg;

    // Read data, one cycle after the strobe; unmapped reads zero
    wire [7:0] rd_mux =
        hit_status  ? {7'h00, nready_reg} :
        hit_flags   ? 8'(flag_reg) :
        hit_control ? {7'h00, pd_reg} :
        hit_mask    ? 8'(mask_reg) :
        hit_pins    ? {5'h00, lp_eff, pin_reg[1], sel} : 8'h00;
    logic [7:0] rdata_reg;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= acc_rd ? rd_mux : 8'h00;             // RL12
    end
    assign reg_rdata = rdata_reg;

    // Checks
    wire [NW-1:0] cor_live = cor_vec & ~ev_vec;

    // Settling cycles counted, as the real deadline is far too long for a delay
    logic [31:0] settle_cnt_reg;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            settle_cnt_reg <= 32'h0;
        else if (nready_reg && !lp_eff)
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
        else
            settle_cnt_reg <= 32'h0;
    end

    a_select_answers: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL2
        !module_select_n [*6] |=> serial_respond_en)
        else $error("select held low but no response enable");
    a_deselect_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL3
        module_select_n [*6] |=> !serial_respond_en)
        else $error("select held high but still responding");
    a_ignore_unsel: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL12
        !serial_respond_en && reg_rd |=> reg_rdata == 8'h00)
        else $error("read answered while not selected");
    a_laser_off: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL9
        tx_laser_disable_in [*6] |=> !laser_enable)
        else $error("laser enabled while disable input high");
    a_laser_on: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL9
        !tx_laser_disable_in [*6] |=> laser_enable)
        else $error("laser off while disable input low");
    a_ready_irq: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL6
        $fell(nready_reg) && !mask_reg[0] |-> flag_reg[0] ##1 !interrupt_out_n)
        else $error("ready not signalled on interrupt");
    a_commit_mask: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL7
        commit |=> mask_reg == $past(mask_pend_reg) && pd_reg == $past(pd_pend_reg))
        else $error("write not committed at scl fall after stop");
    a_no_early: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL7
        !commit |=> $stable(pd_reg))
        else $error("power-down changed before commit edge");
    a_cor_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL8
        |cor_live |=> (flag_reg & $past(cor_live)) == '0)
        else $error("clear-on-read not applied");
    a_irq_release: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL10
        commit && ((flag_reg & ~cor_pend_reg & ~mask_pend_reg) == '0) && (ev_vec == '0)
        ##1 (ev_vec == '0) |=> interrupt_out_n)
        else $error("interrupt not released after read clear");
    a_mask_gate: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL1
        ##1 (interrupt_out_n == ~|($past(flag_reg) & ~$past(mask_reg))))
        else $error("interrupt does not follow flags and mask");
    a_pdown_low: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL4
        $rose(pd_reg) |=> low_power_out && nready_reg)
        else $error("low power not entered");
    a_settle_starts: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL5
        $fell(lp_eff) |=> tmr.busy && nready_reg)
        else $error("settle not started after power-down release");
    a_settle_bound: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL5
        settle_cnt_reg <= SETTLE_CYCLES + 1)
        else $error("settle outlasted its count");

    c_select: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(serial_respond_en));
    c_commit: cover property (@(posedge ref_clk) disable iff (sys_rst) commit);
    c_ready:  cover property (@(posedge ref_clk) disable iff (sys_rst) ready_ev);
    c_corclr: cover property (@(posedge ref_clk) disable iff (sys_rst) |cor_live);

endmodule : mcs_ctrl_status
`default_nettype wire

// *** mcs_host_model.sv ***
// Purpose: Host board controller model: select pin, register port, bus framing
// Assumes: Every access starts on a ref_clk rising edge, strobes one cycle
// Notes:   SCL has a pull-up, so it idles high and falls only to close a frame
`timescale 1ns/1ps
`default_nettype none
module mcs_host_model (
    // Clock
    input  wire logic      ref_clk,
    // Register port
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    // Bus framing and select
    output var  logic       scl_in,
    output var  logic       bus_stop,
    output var  logic       module_select_n
);
    // Idle levels at time zero
    initial
    begin
        reg_addr        = 8'h00;
        reg_wdata       = 8'h00;
        reg_wr          = 1'b0;
        reg_rd          = 1'b0;
        scl_in          = 1'b1;
        bus_stop        = 1'b0;
        module_select_n = 1'b1;
    end

    // Select pin, low means selected
    task automatic sel(input logic v);
        @(posedge ref_clk);
        module_select_n <= v;
    endtask : sel

    // One access; released lines show inverted values so stale data never matches
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= wr;
        reg_rd    <= !wr;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : acc

    // Stop condition, then the SCL fall from which deadlines count
    task automatic frame_end();
        @(posedge ref_clk);
        bus_stop <= 1'b1;
        @(posedge ref_clk);
        bus_stop <= 1'b0;
        repeat (2) @(posedge ref_clk);
        scl_in <= 1'b0;
        repeat (6) @(posedge ref_clk);
        scl_in <= 1'b1;
    endtask : frame_end
endmodule : mcs_host_model
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for the module control and status block
// Assumes: Settle count shortened to 20 cycles; reads checked from a queue
// Notes:   Deadlines are bounded waits far below the required figures
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       ref_clk;
    logic       sys_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       scl_in;
    logic       bus_stop;
    logic       serial_respond_en;
    logic       module_select_n;
    logic       tx_laser_disable_in;
    logic       low_power_pin;
    logic       interrupt_out_n;
    logic       laser_enable;
    logic       low_power_out;
    logic [6:0] flag_event_in;
    logic [7:0] exp_q[$];
    logic       rd_q;
    logic [31:0] seed;
    logic [7:0] a;
    logic [6:0] ev;
    int         err_count;
    int         cmp_count;

    mcs_ctrl_status #(.SETTLE_CYCLES(20), .NFLAGS(7)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
        .bus_stop(bus_stop), .serial_respond_en(serial_respond_en),
        .module_select_n(module_select_n), .tx_laser_disable_in(tx_laser_disable_in),
        .low_power_pin(low_power_pin), .interrupt_out_n(interrupt_out_n),
        .laser_enable(laser_enable), .low_power_out(low_power_out),
        .flag_event_in(flag_event_in));

    mcs_host_model host (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .scl_in(scl_in), .bus_stop(bus_stop),
        .module_select_n(module_select_n));

    // 200 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Bounded wait for an output level: 0 irq, 1 respond, 2 laser, 3 low power
    task automatic wait_pin(input string nm, input int s, input logic v, input int lim);
        logic g;
        int   n;
        n = 0;
        g = ~v;
        while (g !== v && n < lim)
        begin
            @(posedge ref_clk);
            case (s)
                0:       g = interrupt_out_n;
                1:       g = serial_respond_en;
                2:       g = laser_enable;
                default: g = low_power_out;
            endcase
            n++;
        end
        chk(nm, {7'h00, v}, {7'h00, g});
        if (g !== v)
            conclude();
    endtask : wait_pin

    // Reader notes its expectation; the monitor below compares it
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        host.acc(1'b0, ad, 8'h00);
    endtask : rd

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk)
    begin
        if (rd_q)
        begin
            if (exp_q.size() == 0)
                chk("unexpected read", 8'h00, 8'hff);
            else
                chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
        rd_q <= reg_rd;
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    initial
    begin
        err_count = 0;
        cmp_count = 0;
        seed = 32'h00003ce8;
        sys_rst = 1'b1;
        tx_laser_disable_in = 1'b1;
        low_power_pin = 1'b0;
        flag_event_in = 7'h00;
        repeat (10) @(posedge ref_clk);
        chk("reset outputs", 8'h08,
            {4'h0, interrupt_out_n, laser_enable, low_power_out, serial_respond_en});
        sys_rst <= 1'b0;
        wait_pin("ready irq", 0, 1'b0, 40);
        host.sel(1'b0);
        wait_pin("respond on", 1, 1'b1, 20);
        rd(mcs_pkg::ADDR_STATUS, 8'h00);
        $display("Startup test done");
        // Clear-on-read waits for stop and SCL fall
        rd(mcs_pkg::ADDR_FLAGS, 8'h01);
        repeat (8) @(posedge ref_clk);
        chk("irq before stop", 8'h00, {7'h00, interrupt_out_n});
        host.frame_end();
        wait_pin("irq release", 0, 1'b1, 20);
        $display("Clear-on-read test done");
        // Random events, mask set and clear
        seed = xs(seed);
        ev = seed[6:0] | 7'h01;
        @(posedge ref_clk);
        flag_event_in <= ev;
        @(posedge ref_clk);
        flag_event_in <= 7'h00;
        wait_pin("event irq", 0, 1'b0, 20);
        host.acc(1'b1, mcs_pkg::ADDR_MASK, 8'hff);
        repeat (8) @(posedge ref_clk);
        chk("mask pending", 8'h00, {7'h00, interrupt_out_n});
        host.frame_end();
        wait_pin("mask inhibit", 0, 1'b1, 20);
        rd(mcs_pkg::ADDR_MASK, 8'hff);
        host.acc(1'b1, mcs_pkg::ADDR_MASK, 8'h00);
        host.frame_end();
        wait_pin("mask resume", 0, 1'b0, 20);
        rd(mcs_pkg::ADDR_FLAGS, {ev, 1'b0});
        host.acc(1'b1, mcs_pkg::ADDR_FLAGS, 8'hfe);
        wait_pin("w1c release", 0, 1'b1, 20);
        $display("Mask test done");
        // Unmapped addresses read zero and ignore writes
        repeat (4)
        begin
            seed = xs(seed);
            a = seed[7:0];
            if (a != mcs_pkg::ADDR_STATUS && a != mcs_pkg::ADDR_FLAGS
                && a != mcs_pkg::ADDR_CONTROL && a != mcs_pkg::ADDR_MASK
                && a != mcs_pkg::ADDR_PINS)
            begin
                host.acc(1'b1, a, seed[15:8]);
                rd(a, 8'h00);
            end
        end
        // Power-down override and low power pin
        host.acc(1'b1, mcs_pkg::ADDR_CONTROL, 8'h01);
        host.frame_end();
        wait_pin("pdown enter", 3, 1'b1, 20);
        rd(mcs_pkg::ADDR_STATUS, 8'h01);
        rd(mcs_pkg::ADDR_CONTROL, 8'h01);
        host.acc(1'b1, mcs_pkg::ADDR_CONTROL, 8'h00);
        host.frame_end();
        wait_pin("pdown leave", 3, 1'b0, 20);
        wait_pin("ready again", 0, 1'b0, 40);
        rd(mcs_pkg::ADDR_STATUS, 8'h00);
        @(posedge ref_clk);
        low_power_pin <= 1'b1;
        wait_pin("pin low power", 3, 1'b1, 10);
        low_power_pin <= 1'b0;
        wait_pin("pin full power", 3, 1'b0, 10);
        $display("Power test done");
        // Laser follows the disable input
        tx_laser_disable_in <= 1'b0;
        wait_pin("laser on", 2, 1'b1, 10);
        rd(mcs_pkg::ADDR_PINS, 8'h01);
        tx_laser_disable_in <= 1'b1;
        wait_pin("laser off", 2, 1'b0, 10);
        // Deselected traffic is ignored
        host.sel(1'b1);
        wait_pin("respond off", 1, 1'b0, 20);
        host.acc(1'b1, mcs_pkg::ADDR_MASK, 8'hff);
        host.frame_end();
        host.sel(1'b0);
        wait_pin("respond again", 1, 1'b1, 20);
        rd(mcs_pkg::ADDR_MASK, 8'h00);
        $display("Select test done");
        repeat (4) @(posedge ref_clk);
        chk("reads left", 8'h00, 8'(exp_q.size()));
        conclude();
    end
endmodule : testbench
`default_nettype wire
